// ---- verilog/nvx_defines.vh ----
/*
 * Constants for the nine-pin I/O expander serial slave: memory map offsets,
 * reset values, bus address fields and timing counts.
 * Assumes a 50 MHz system clock; included by bare name from verilog/.
 */
`ifndef NVX_DEFINES_VH
`define NVX_DEFINES_VH

// ****************************************************************
// memory map
// ****************************************************************
`define NVX_USER_LAST 8'h3F
`define NVX_RSVD_LAST 8'hE7
`define NVX_PULLUP_LOW 8'hF0
`define NVX_PULLUP_HIGH 8'hF1
`define NVX_DRIVE_LOW 8'hF2
`define NVX_DRIVE_HIGH 8'hF3
`define NVX_CONFIG 8'hF4
`define NVX_UPPER_USER_FIRST 8'hF5
`define NVX_UPPER_USER_LAST 8'hF7
`define NVX_LEVEL_LOW 8'hF8
`define NVX_LEVEL_HIGH 8'hF9
`define NVX_SCRATCH_FIRST 8'hFA

// ****************************************************************
// reset values
// ****************************************************************
`define NVX_USER_RESET 8'h00
`define NVX_PULLUP_RESET 8'h00
`define NVX_DRIVE_LOW_RESET 8'hFF
`define NVX_DRIVE_HIGH_RESET 8'h01
`define NVX_CONFIG_RESET 8'h00
`define NVX_SHADOW_ONLY_BIT 0

// ****************************************************************
// bus address byte
// ****************************************************************
`define NVX_DEVICE_CODE 4'hA
`define NVX_ROW_MASK 8'hF8

// ****************************************************************
// timing
// ****************************************************************
`define NVX_CLOCK_MHZ 50
`define NVX_NV_WRITE_US 20
`define NVX_NV_WRITE_CYCLES (`NVX_NV_WRITE_US * `NVX_CLOCK_MHZ)

`endif

// ---- verilog/nvx_sync.v ----
/*
 * Three-stage synchroniser bank for pin inputs.
 * Assumes inputs are asynchronous to clock; out changes once stages two and three agree.
 */
`timescale 1ns/10ps
`default_nettype none
module nvx_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
    input wire clock,
    input wire rst_n,
    input wire [WIDTH-1:0] in_async,
    output reg [WIDTH-1:0] out
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    stage1[i] <= RESET_VALUE[i];
                    stage2[i] <= RESET_VALUE[i];
                    stage3[i] <= RESET_VALUE[i];
                    out[i] <= RESET_VALUE[i];
                end else begin
                    stage1[i] <= in_async[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    // stage one feeds stage two only
                    if (stage2[i] == stage3[i]) begin
                        out[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verilog/nvx_nv_timer.v ----
/*
 * Nonvolatile write-cycle timer: busy for a fixed count after a start pulse.
 * Assumes start is a one-cycle pulse on clock.
 */
`timescale 1ns/10ps
`default_nettype none
module nvx_nv_timer #(
    parameter CYCLES = 1000
) (
    input wire clock,
    input wire rst_n,
    input wire start,
    output wire busy
);
    reg [23:0] count;
    assign busy = (count != 24'h000000);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 24'h000000;
        end else if (start) begin
            count <= CYCLES[23:0];
        end else if (busy) begin
            count <= count - 24'h000001;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/nvx_serial_slave.v ----
/*
 * Two-wire serial slave of a nine-pin open-drain I/O expander with user
 * memory, pull-up and drive registers, pin status and scratch RAM.
 * Assumes a master drives scl and the sda wire level is resolved outside
 * from sda_oe (low while asserted).  Straps and pins are asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
`include "nvx_defines.vh"
module nvx_serial_slave #(
    parameter NV_WRITE_CYCLES = `NVX_NV_WRITE_CYCLES
) (
    input wire clock,
    input wire rst_n,
    input wire scl,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    input wire addr_strap_0,
    input wire addr_strap_1,
    input wire addr_strap_2,
    input wire [8:0] pin_in,
    output wire [8:0] pin_drive_low,
    output wire [8:0] pullup_on,
    output wire nv_busy
);
    // ****************************************************************
    // states
    // ****************************************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_ADDR_ACK = 3'h2;
    localparam ST_WRITE = 3'h3;
    localparam ST_WRITE_ACK = 3'h4;
    localparam ST_READ = 3'h5;
    localparam ST_READ_ACK = 3'h6;

    // ****************************************************************
    // input synchronisation
    // ****************************************************************
    wire [13:0] sync_out;
    nvx_sync #(
        .WIDTH(14),
        .RESET_VALUE(14'h3FFF)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .in_async({addr_strap_2, addr_strap_1, addr_strap_0, pin_in, sda_in, scl}),
        .out(sync_out)
    );
    wire scl_s = sync_out[0];
    wire sda_s = sync_out[1];
    wire [8:0] pin_s = sync_out[10:2];
    wire [2:0] strap_s = sync_out[13:11];

    reg scl_d;
    reg sda_d;
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    wire start_cond = scl_s && scl_d && sda_d && !sda_s;
    wire stop_cond = scl_s && scl_d && !sda_d && sda_s;

    // ****************************************************************
    // storage
    // ****************************************************************
    reg [7:0] user_mem [0:63];
    reg [7:0] upper_user [0:2];
    reg [7:0] scratch [0:5];
    reg [7:0] pullup_enable_low;
    reg [7:0] pullup_enable_high;
    reg [7:0] output_drive_low;
    reg [7:0] output_drive_high;
    reg [7:0] configuration;
    // nonvolatile copies of the shadowed registers, written when shadow-only is clear
    reg [7:0] nv_pullup_low;
    reg [7:0] nv_pullup_high;
    reg [7:0] nv_drive_low;
    reg [7:0] nv_drive_high;

    assign pullup_on = {pullup_enable_high[0], pullup_enable_low};
    assign pin_drive_low = ~{output_drive_high[0], output_drive_low};

    // ****************************************************************
    // protocol state
    // ****************************************************************
    reg [2:0] state;
    reg [3:0] bit_count;
    reg [7:0] shift;
    reg [7:0] addr_counter;
    reg first_data;
    reg nv_dirty;
    reg nv_start;
    assign sda_out = 1'b0;

    wire [6:0] own_address = {`NVX_DEVICE_CODE, strap_s};
    wire [7:0] next_addr_wrap = (addr_counter & `NVX_ROW_MASK) |
        ((addr_counter + 8'h01) & ~`NVX_ROW_MASK);

    // read multiplexer; reserved space reads zero
    reg [7:0] read_data;
    always @* begin
        read_data = 8'h00;
        if (addr_counter <= `NVX_USER_LAST) begin
            read_data = user_mem[addr_counter[5:0]];
        end else if (addr_counter == `NVX_PULLUP_LOW) begin
            read_data = pullup_enable_low;
        end else if (addr_counter == `NVX_PULLUP_HIGH) begin
            read_data = pullup_enable_high;
        end else if (addr_counter == `NVX_DRIVE_LOW) begin
            read_data = output_drive_low;
        end else if (addr_counter == `NVX_DRIVE_HIGH) begin
            read_data = output_drive_high;
        end else if (addr_counter == `NVX_CONFIG) begin
            read_data = configuration;
        end else if (addr_counter >= `NVX_UPPER_USER_FIRST &&
                     addr_counter <= `NVX_UPPER_USER_LAST) begin
            read_data = upper_user[addr_counter[1:0] - 2'h1];
        end else if (addr_counter == `NVX_LEVEL_LOW) begin
            read_data = pin_s[7:0];
        end else if (addr_counter == `NVX_LEVEL_HIGH) begin
            read_data = {7'h00, pin_s[8]};
        end else if (addr_counter >= `NVX_SCRATCH_FIRST) begin
            read_data = scratch[addr_counter[2:0] - 3'h2];
        end
    end

    nvx_nv_timer #(
        .CYCLES(NV_WRITE_CYCLES)
    ) u_nv_timer (
        .clock(clock),
        .rst_n(rst_n),
        .start(nv_start),
        .busy(nv_busy)
    );

    integer k;
    wire shadow_only = configuration[`NVX_SHADOW_ONLY_BIT];

    // ****************************************************************
    // bus engine
    // ****************************************************************
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= ST_IDLE;
            bit_count <= 4'h0;
            shift <= 8'h00;
            addr_counter <= 8'h00;
            first_data <= 1'b0;
            sda_oe <= 1'b0;
            nv_dirty <= 1'b0;
            nv_start <= 1'b0;
            pullup_enable_low <= `NVX_PULLUP_RESET;
            pullup_enable_high <= `NVX_PULLUP_RESET;
            output_drive_low <= `NVX_DRIVE_LOW_RESET;
            output_drive_high <= `NVX_DRIVE_HIGH_RESET;
            configuration <= `NVX_CONFIG_RESET;
            nv_pullup_low <= `NVX_PULLUP_RESET;
            nv_pullup_high <= `NVX_PULLUP_RESET;
            nv_drive_low <= `NVX_DRIVE_LOW_RESET;
            nv_drive_high <= `NVX_DRIVE_HIGH_RESET;
            for (k = 0; k < 64; k = k + 1) begin
                user_mem[k] <= `NVX_USER_RESET;
            end
            for (k = 0; k < 3; k = k + 1) begin
                upper_user[k] <= `NVX_USER_RESET;
            end
            for (k = 0; k < 6; k = k + 1) begin
                scratch[k] <= 8'h00;
            end
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            nv_start <= 1'b0;
            if (start_cond) begin
                // repeated start also lands here; counter is kept
                state <= ST_ADDR;
                bit_count <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
                if (nv_dirty) begin
                    nv_start <= 1'b1;
                    nv_dirty <= 1'b0;
                end
            end else begin
                case (state)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_s};
                            bit_count <= bit_count + 4'h1;
                        end else if (scl_fall && bit_count == 4'h8) begin
                            if (shift[7:1] == own_address && !nv_busy) begin
                                sda_oe <= 1'b1;
                                state <= ST_ADDR_ACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_count <= 4'h0;
                            if (shift[0]) begin
                                state <= ST_READ;
                                shift <= {read_data[6:0], 1'b0};
                                sda_oe <= !read_data[7];
                            end else begin
                                state <= ST_WRITE;
                                first_data <= 1'b1;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_s};
                            bit_count <= bit_count + 4'h1;
                        end else if (scl_fall && bit_count == 4'h8) begin
                            sda_oe <= 1'b1;
                            state <= ST_WRITE_ACK;
                        end
                    end
                    ST_WRITE_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            bit_count <= 4'h0;
                            state <= ST_WRITE;
                            first_data <= 1'b0;
                            if (first_data) begin
                                addr_counter <= shift;
                            end else begin
                                addr_counter <= next_addr_wrap;
                                if (addr_counter <= `NVX_USER_LAST) begin
                                    user_mem[addr_counter[5:0]] <= shift;
                                    nv_dirty <= 1'b1;
                                end else if (addr_counter == `NVX_PULLUP_LOW) begin
                                    pullup_enable_low <= shift;
                                    if (!shadow_only) begin
                                        nv_pullup_low <= shift;
                                        nv_dirty <= 1'b1;
                                    end
                                end else if (addr_counter == `NVX_PULLUP_HIGH) begin
                                    pullup_enable_high <= {7'h00, shift[0]};
                                    if (!shadow_only) begin
                                        nv_pullup_high <= {7'h00, shift[0]};
                                        nv_dirty <= 1'b1;
                                    end
                                end else if (addr_counter == `NVX_DRIVE_LOW) begin
                                    output_drive_low <= shift;
                                    if (!shadow_only) begin
                                        nv_drive_low <= shift;
                                        nv_dirty <= 1'b1;
                                    end
                                end else if (addr_counter == `NVX_DRIVE_HIGH) begin
                                    output_drive_high <= {7'h00, shift[0]};
                                    if (!shadow_only) begin
                                        nv_drive_high <= {7'h00, shift[0]};
                                        nv_dirty <= 1'b1;
                                    end
                                end else if (addr_counter == `NVX_CONFIG) begin
                                    configuration <= {7'h00, shift[0]};
                                    nv_dirty <= 1'b1;
                                end else if (addr_counter >= `NVX_UPPER_USER_FIRST &&
                                             addr_counter <= `NVX_UPPER_USER_LAST) begin
                                    upper_user[addr_counter[1:0] - 2'h1] <= shift;
                                    nv_dirty <= 1'b1;
                                end else if (addr_counter >= `NVX_SCRATCH_FIRST) begin
                                    scratch[addr_counter[2:0] - 3'h2] <= shift;
                                end
                                // reserved, E8h-EFh and status writes fall through
                            end
                        end
                    end
                    ST_READ: begin
                        if (scl_rise) begin
                            bit_count <= bit_count + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_count == 4'h8) begin
                                sda_oe <= 1'b0; // master owns the ack slot
                                addr_counter <= addr_counter + 8'h01;
                                state <= ST_READ_ACK;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                                sda_oe <= !shift[7];
                            end
                        end
                    end
                    ST_READ_ACK: begin
                        if (scl_rise) begin
                            // nack ends the read and leaves sda released
                            if (sda_s) begin
                                state <= ST_IDLE;
                            end else begin
                                bit_count <= 4'h0;
                            end
                        end else if (scl_fall) begin
                            state <= ST_READ;
                            shift <= {read_data[6:0], 1'b0};
                            sda_oe <= !read_data[7];
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/nvx_serial_slave_assertions.sv ----
/* Port checker for the expander serial slave.
   Assumes a bind by name from the bench and a pulled-up data wire on sda_in. */
`timescale 1ns/10ps
`default_nettype none
module nvx_serial_slave_assertions #(
    parameter NV_WRITE_CYCLES = 200
) (
    input wire clock,
    input wire rst_n,
    input wire scl,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire [8:0] pin_drive_low,
    input wire [8:0] pullup_on,
    input wire nv_busy
);
    localparam int LO = NV_WRITE_CYCLES - 2;
    localparam int HI = NV_WRITE_CYCLES + 2;
    logic idle;
    logic [10:0] busy_cnt;
    logic [4:0] oe_age;
    // ********
    // bus state seen from the raw wires
    // ********
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idle <= 1'b1;
            busy_cnt <= 11'h000;
            oe_age <= 5'h1F;
        end else begin
            if (scl && $past(scl) && sda_in && !$past(sda_in))
                idle <= 1'b1;
            else if (scl && $past(scl) && !sda_in && $past(sda_in))
                idle <= 1'b0;
            busy_cnt <= nv_busy ? busy_cnt + 11'h001 : 11'h000;
            oe_age <= sda_oe ? 5'h00 : (oe_age == 5'h1F ? oe_age : oe_age + 5'h01);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_open_drain; sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data output value not low");
    // device edges land only while the clock is low
    property p_oe_low_scl; $changed(sda_oe) |-> !$past(scl, 2); endproperty
    a_oe_low_scl: assert property (p_oe_low_scl)
        else $error("data line changed while clock high");
    property p_busy_nak; $rose(sda_oe) |-> !$past(nv_busy); endproperty
    a_busy_nak: assert property (p_busy_nak)
        else $error("answered while write cycle busy");
    property p_busy_stop; $rose(nv_busy) |-> idle && $past(scl, 2); endproperty
    a_busy_stop: assert property (p_busy_stop)
        else $error("write cycle began without a stop");
    property p_busy_len; $fell(nv_busy) |-> busy_cnt >= LO && busy_cnt <= HI; endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("write cycle length wrong");
    property p_pull_upd; $changed(pullup_on) |-> (oe_age < 24) or (##[0:12] sda_oe); endproperty
    a_pull_upd: assert property (p_pull_upd)
        else $error("pull-up changed outside a write");
    property p_drive_upd; $changed(pin_drive_low) |-> (oe_age < 24) or (##[0:12] sda_oe); endproperty
    a_drive_upd: assert property (p_drive_upd)
        else $error("drive changed outside a write");
    property p_idle_free; idle |-> !sda_oe; endproperty
    a_idle_free: assert property (p_idle_free)
        else $error("data line held while bus idle");
endmodule
`default_nettype wire

// ---- dv/nvx_bus_master.sv ----
/* Behavioural two-wire bus master: start, stop, byte write, byte read.
   Assumes the bench resolves the wire with a pull-up and feeds it to sda. */
`timescale 1ns/10ps
`default_nettype none
module nvx_bus_master (
    input wire logic clock,
    input wire logic sda,
    output var logic scl,
    output var logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic q(input int n);
        repeat (n) @(posedge clock);
    endtask
    // extra low time lets the device drop a held ack first
    task automatic start();
        sda_drv <= 1'b1;
        q(6);
        scl <= 1'b1;
        q(2);
        sda_drv <= 1'b0;
        q(2);
        scl <= 1'b0;
        q(2);
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        q(6);
        scl <= 1'b1;
        q(2);
        sda_drv <= 1'b1;
        q(8);
    endtask
    task automatic bit_x(input logic b, output logic r);
        q(2);
        sda_drv <= b;
        // low phase of 6 clocks outlasts the device's 5-clock reply latency
        q(4);
        scl <= 1'b1;
        q(1);
        r = sda;
        q(1);
        scl <= 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(last, r);
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
/* Self-checking bench for the expander serial slave.
   Assumes the master model and the port checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clock, rst_n, scl, sda_drv, sda_oe, sda_out, nv_busy, k;
    logic [2:0] strap;
    logic [8:0] pin_in, pin_drive_low, pullup_on;
    logic [31:0] seed;
    logic [7:0] dev;
    logic [7:0] wd [0:7];
    logic [7:0] rdv [0:7];
    int bad_count = 0, tests_run = 0, cycles = 0;
    wire sda = sda_drv & ~(sda_oe & ~sda_out);
    nvx_serial_slave #(.NV_WRITE_CYCLES(200)) nvx_serial_slave_i (.clock(clock), .rst_n(rst_n),
        .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_0(strap[0]),
        .addr_strap_1(strap[1]), .addr_strap_2(strap[2]), .pin_in(pin_in),
        .pin_drive_low(pin_drive_low), .pullup_on(pullup_on), .nv_busy(nv_busy));
    nvx_bus_master nvx_bus_master_i (.clock(clock), .sda(sda), .scl(scl), .sda_drv(sda_drv));
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [7:0] reg_reset(input int i);
        return (i == 2) ? 8'hFF : (i == 3) ? 8'h01 : 8'h00;
    endfunction
    task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic settle();
        for (int i = 0; i < 300 && nv_busy !== 1'b0; i++) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input int n, input logic sp);
        nvx_bus_master_i.start();
        nvx_bus_master_i.wbyte(dev, k);
        chk("dev ack", 9'(k), 9'h001);
        nvx_bus_master_i.wbyte(a, k);
        chk("addr ack", 9'(k), 9'h001);
        for (int i = 0; i < n; i++) begin
            nvx_bus_master_i.wbyte(wd[i], k);
            chk("data ack", 9'(k), 9'h001);
        end
        if (sp)
            nvx_bus_master_i.stop();
    endtask
    // read through a dummy write and a repeated start
    task automatic rd(input logic [7:0] a, input int n);
        wr(a, 0, 1'b0);
        nvx_bus_master_i.start();
        nvx_bus_master_i.wbyte(dev | 8'h01, k);
        chk("read ack", 9'(k), 9'h001);
        for (int i = 0; i < n; i++) nvx_bus_master_i.rbyte(i == n - 1, rdv[i]);
        nvx_bus_master_i.stop();
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            finish_test();
        end
    end
    // ********
    // main sequence
    // ********
    initial begin
        seed = 32'h53BC;
        rst_n = 1'b0;
        strap = 3'h0;
        pin_in = 9'h000;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        dev = 8'hA0;
        chk("drive", pin_drive_low, 9'h000);
        chk("pull", pullup_on, 9'h000);
        rd(8'hF0, 5);
        for (int i = 0; i < 5; i++) chk("reset", 9'(rdv[i]), 9'(reg_reset(i)));
        for (int s = 0; s < 8; s++) begin
            strap <= 3'(s);
            repeat (6) @(posedge clock);
            dev = {4'hA, 3'(s), 1'b0};
            nvx_bus_master_i.start();
            nvx_bus_master_i.wbyte({4'hA, ~3'(s), 1'b0}, k);
            chk("foreign", 9'(k), 9'h000);
            nvx_bus_master_i.wbyte(dev, k);
            chk("no start", 9'(k), 9'h000);
            nvx_bus_master_i.start();
            nvx_bus_master_i.wbyte(dev, k);
            chk("match", 9'(k), 9'h001);
            nvx_bus_master_i.stop();
        end
        for (int i = 0; i < 4; i++) wd[i] = rnd();
        wr(8'hF0, 4, 1'b1);
        chk("nv busy", 9'(nv_busy), 9'h001);
        chk("pull", pullup_on, {wd[1][0], wd[0]});
        chk("drive", pin_drive_low, ~{wd[3][0], wd[2]});
        nvx_bus_master_i.start();
        nvx_bus_master_i.wbyte(dev, k);
        chk("poll", 9'(k), 9'h000);
        nvx_bus_master_i.stop();
        settle();
        wd[0] = 8'h01;
        wr(8'hF4, 1, 1'b1);
        settle();
        wd[0] = rnd();
        wr(8'hF2, 1, 1'b1);
        chk("shadow", 9'(nv_busy), 9'h000);
        chk("drive", {1'b0, pin_drive_low[7:0]}, {1'b0, ~wd[0]});
        wd[0] = 8'h00;
        wr(8'hF4, 1, 1'b1);
        settle();
        for (int i = 0; i < 8; i++) wd[i] = rnd() | 8'h01;
        wr(8'h3D, 4, 1'b1);
        settle();
        rd(8'h3D, 4);
        for (int i = 0; i < 3; i++) chk("user", 9'(rdv[i]), 9'(wd[i]));
        chk("past row", 9'(rdv[3]), 9'h000);
        rd(8'h38, 1);
        chk("wrap", 9'(rdv[0]), 9'(wd[3]));
        wr(8'h50, 1, 1'b1);
        settle();
        wr(8'hF8, 2, 1'b1);
        settle();
        pin_in <= 9'({rnd(), rnd()});
        wr(8'hFA, 6, 1'b1);
        rd(8'h50, 1);
        chk("reserved", 9'(rdv[0]), 9'h000);
        rd(8'hF8, 8);
        chk("pins lo", 9'(rdv[0]), 9'(pin_in[7:0]));
        chk("pin 8", 9'(rdv[1][0]), 9'(pin_in[8]));
        for (int i = 2; i < 8; i++) chk("scratch", 9'(rdv[i]), 9'(wd[i - 2]));
        finish_test();
    end
endmodule
bind nvx_serial_slave nvx_serial_slave_assertions #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES))
    nvx_serial_slave_assertions_i (.clock(clock), .rst_n(rst_n), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .pin_drive_low(pin_drive_low),
    .pullup_on(pullup_on), .nv_busy(nv_busy));
`default_nettype wire
